// ===== core/bcd_cfg_reg.v
`default_nettype none
// One configuration byte with write gate and reset value
module bcd_cfg_reg #(
    parameter [7:0] RST_VAL = 8'h00
) (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       rst_b,
    input  wire       clk_en,
    // Write port
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    // Stored value
    output reg  [7:0] q_r
);
    // Reset to listed default, load only when gated write arrives
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            q_r <= RST_VAL;
        end else if (clk_en && wr_en) begin
            q_r <= wr_data;
        end
    end
endmodule // bcd_cfg_reg
`default_nettype wire

// ===== core/bcd_err_flag.v
`default_nettype none
// Sticky error bit, set beats clear
module bcd_err_flag (
    // Clock and reset
    input  wire sys_clk,
    input  wire rst_b,
    input  wire clk_en,
    // Events
    input  wire set_ev,
    input  wire clr_ev,
    // Latched flag
    output reg  flag_r
);
    // Set wins so an event in the clearing cycle is kept
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_r <= 1'b0;
        end else if (clk_en) begin
            if (set_ev) begin
                flag_r <= 1'b1;
            end else if (clr_ev) begin
                flag_r <= 1'b0;
            end
        end
    end
endmodule // bcd_err_flag
`default_nettype wire

// ===== core/bcd_map.vh
`ifndef BCD_MAP_VH
`define BCD_MAP_VH
// Register offsets (7-bit address)
`define BCD_A_GATE_ROUTE      7'h02
`define BCD_A_DIV1            7'h09
`define BCD_A_DIV2            7'h0A
`define BCD_A_PHEN1           7'h0B
`define BCD_A_PHEN2           7'h0C
`define BCD_A_PHTIM1          7'h0D
`define BCD_A_PHTIM2          7'h0E
`define BCD_A_GATE_PHASE      7'h0F
`define BCD_A_PHASE_ASSIGN    7'h10
`define BCD_A_PROP            7'h11
`define BCD_A_INTEG           7'h12
`define BCD_A_SLOPE           7'h13
`define BCD_A_SENSE_R         7'h14
`define BCD_A_GATE_SUPPLY     7'h15
`define BCD_A_HID_A           7'h19
`define BCD_A_IN_HIGH         7'h1A
`define BCD_A_IN_LOW          7'h1B
`define BCD_A_HID_B           7'h25
`define BCD_A_HID_C           7'h26
`define BCD_A_HID_D           7'h2F
`define BCD_A_HID_E           7'h30
`define BCD_A_SEL_CNT_LO      7'h41
`define BCD_A_SEL_CNT_HI      7'h42
`define BCD_A_IN_SUPPLY       7'h45
`define BCD_A_DIE_TEMP        7'h46
`define BCD_A_CALIB           7'h4C
`define BCD_A_HEALTH          7'h5F
// Reset values
`define BCD_R_GATE_ROUTE      8'h00
`define BCD_R_DIV             8'h0F
`define BCD_R_PHEN            8'h0F
`define BCD_R_PHTIM           8'h39
`define BCD_R_GATE_PHASE      8'h00
`define BCD_R_PHASE_ASSIGN    8'hE4
`define BCD_R_GAIN            8'h00
`define BCD_R_SLOPE           8'h88
`define BCD_R_SENSE_R         8'h00
`define BCD_R_GATE_SUPPLY     8'hFF
`define BCD_R_HID_A           8'h82
`define BCD_R_IN_HIGH         8'hFF
`define BCD_R_IN_LOW          8'h00
`define BCD_R_HID_B           8'h27
`define BCD_R_HID_C           8'h3B
`define BCD_R_HID_D           8'hE8
`define BCD_R_HID_E           8'h09
// Field positions
`define BCD_F_PHDEL_HI        7
`define BCD_F_PHDEL_LO        3
`define BCD_F_PHOFF_HI        2
`define BCD_F_PHOFF_LO        0
`define BCD_F_OUT1_OK         7
`define BCD_F_OUT2_OK         6
`define BCD_F_GS_OK           5
`define BCD_F_OVERTEMP        4
`define BCD_F_IN_LOW          3
`define BCD_F_IN_HIGH         2
`define BCD_F_SER_ERR         1
`define BCD_F_GS_FAULT        0
`endif

// ===== core/bcd_regs.v
// Behaviour
// - Configuration writes only in configuration mode
// - Two eight-bit clock dividers, reset 0Fh
// - Per-output phase enables, low nibble, reset 0Fh
// - Phase timing: delay 7:3, off 2:0
// - Gain nibbles: output one low, two high
// - Diagnostic registers ignore writes
// - Status write clears latched error flags
// - Locked config write sets serial error
`include "bcd_map.vh"
`default_nettype none
module bcd_regs (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst_b,
    input  wire        clk_en,
    // Register access from frame engine
    input  wire        acc_wr,
    input  wire        acc_rd,
    input  wire [6:0]  acc_addr,
    input  wire [7:0]  acc_wdata,
    input  wire        frame_bad,
    output reg  [7:0]  acc_rdata_r,
    output reg         acc_ok_r,
    // Mode
    input  wire        cfg_mode,
    // Live monitor inputs
    input  wire        out1_in_range,
    input  wire        out2_in_range,
    input  wire        gs_in_range,
    input  wire        overtemp_ev,
    input  wire        in_low_ev,
    input  wire        in_high_ev,
    input  wire        gs_fault_ev,
    input  wire [15:0] sel_edge_count,
    input  wire [7:0]  in_supply_meas,
    input  wire [7:0]  die_temp_meas,
    input  wire [7:0]  calib_result,
    // Configuration outputs
    output reg  [3:0]  gate_output_route_r,
    output reg  [7:0]  output1_divider_value_r,
    output reg  [7:0]  output2_divider_value_r,
    output reg  [3:0]  output1_phase_on_r,
    output reg  [3:0]  output2_phase_on_r,
    output reg  [4:0]  output1_phase_delay_r,
    output reg  [2:0]  output1_phase_off_r,
    output reg  [4:0]  output2_phase_delay_r,
    output reg  [2:0]  output2_phase_off_r,
    output reg  [3:0]  gate_phase_route_r,
    output reg  [7:0]  phase_output_choice_r,
    output reg  [3:0]  output1_proportional_gain_r,
    output reg  [3:0]  output2_proportional_gain_r,
    output reg  [3:0]  output1_integral_gain_r,
    output reg  [3:0]  output2_integral_gain_r,
    output reg  [7:0]  slope_comp_r,
    output reg  [7:0]  phase_sense_resistor_r,
    output reg  [7:0]  gate_supply_setting_r,
    output reg  [7:0]  input_high_limit_r,
    output reg  [7:0]  input_low_limit_r,
    output reg  [7:0]  health_status_r
);
    localparam NREG = 20;

    // Table of addresses and reset values, one entry per stored byte except the last hidden setting
    function [6:0] reg_addr;
        input integer i;
        begin
            case (i)
                0:       reg_addr = `BCD_A_GATE_ROUTE;
                1:       reg_addr = `BCD_A_DIV1;
                2:       reg_addr = `BCD_A_DIV2;
                3:       reg_addr = `BCD_A_PHEN1;
                4:       reg_addr = `BCD_A_PHEN2;
                5:       reg_addr = `BCD_A_PHTIM1;
                6:       reg_addr = `BCD_A_PHTIM2;
                7:       reg_addr = `BCD_A_GATE_PHASE;
                8:       reg_addr = `BCD_A_PHASE_ASSIGN;
                9:       reg_addr = `BCD_A_PROP;
                10:      reg_addr = `BCD_A_INTEG;
                11:      reg_addr = `BCD_A_SLOPE;
                12:      reg_addr = `BCD_A_SENSE_R;
                13:      reg_addr = `BCD_A_GATE_SUPPLY;
                14:      reg_addr = `BCD_A_IN_HIGH;
                15:      reg_addr = `BCD_A_IN_LOW;
                16:      reg_addr = `BCD_A_HID_A;
                17:      reg_addr = `BCD_A_HID_B;
                18:      reg_addr = `BCD_A_HID_C;
                default: reg_addr = `BCD_A_HID_D;
            endcase
        end
    endfunction

    function [7:0] reg_rst;
        input integer i;
        begin
            case (i)
                0:       reg_rst = `BCD_R_GATE_ROUTE;
                1:       reg_rst = `BCD_R_DIV;
                2:       reg_rst = `BCD_R_DIV;
                3:       reg_rst = `BCD_R_PHEN;
                4:       reg_rst = `BCD_R_PHEN;
                5:       reg_rst = `BCD_R_PHTIM;
                6:       reg_rst = `BCD_R_PHTIM;
                7:       reg_rst = `BCD_R_GATE_PHASE;
                8:       reg_rst = `BCD_R_PHASE_ASSIGN;
                9:       reg_rst = `BCD_R_GAIN;
                10:      reg_rst = `BCD_R_GAIN;
                11:      reg_rst = `BCD_R_SLOPE;
                12:      reg_rst = `BCD_R_SENSE_R;
                13:      reg_rst = `BCD_R_GATE_SUPPLY;
                14:      reg_rst = `BCD_R_IN_HIGH;
                15:      reg_rst = `BCD_R_IN_LOW;
                16:      reg_rst = `BCD_R_HID_A;
                17:      reg_rst = `BCD_R_HID_B;
                18:      reg_rst = `BCD_R_HID_C;
                default: reg_rst = `BCD_R_HID_D;
            endcase
        end
    endfunction

    // Entries below this index are configuration group (mode locked)
    localparam NCFG = 16;

    wire [NREG*8-1:0] store_q;
    wire [NREG-1:0]   hit;
    reg  [7:0]        hid_e_r;

    // Address decode and storage, one entry per table register
    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1) begin : g_reg
            // Hidden settings sit above the config entries and are never locked
            wire lock_ok = (g < NCFG) ? cfg_mode : 1'b1;
            assign hit[g] = (acc_addr == reg_addr(g));
            bcd_cfg_reg #(
                .RST_VAL (reg_rst(g))
            ) u_reg (
                .sys_clk (sys_clk),
                .rst_b   (rst_b),
                .clk_en  (clk_en),
                .wr_en   (acc_wr & hit[g] & lock_ok & ~frame_bad),
                .wr_data (acc_wdata),
                .q_r     (store_q[g*8 +: 8])
            );
        end
    endgenerate

    // Last hidden setting kept locally; host is expected to leave it alone
    wire hit_e = (acc_addr == `BCD_A_HID_E);
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            hid_e_r <= `BCD_R_HID_E;
        end else if (clk_en && acc_wr && hit_e && !frame_bad) begin
            hid_e_r <= acc_wdata;
        end
    end

    // Address classes
    wire cfg_hit    = |hit[NCFG-1:0];
    wire diag_hit   = (acc_addr == `BCD_A_SEL_CNT_LO) ||
                      (acc_addr == `BCD_A_SEL_CNT_HI) ||
                      (acc_addr == `BCD_A_IN_SUPPLY)  ||
                      (acc_addr == `BCD_A_DIE_TEMP)   ||
                      (acc_addr == `BCD_A_CALIB);
    wire health_hit = (acc_addr == `BCD_A_HEALTH);
    wire known      = (|hit) | hit_e | diag_hit | health_hit;

    // Erroneous access: locked config write, read-only write, unmapped, bad length
    wire bad_acc = frame_bad |
                   (acc_wr & cfg_hit & ~cfg_mode) |
                   (acc_wr & diag_hit) |
                   ((acc_wr | acc_rd) & ~known);

    // Latched error flags
    // Clear needs a clean frame; a set in the same cycle still wins
    wire ser_err_q;
    wire ot_q;
    wire inl_q;
    wire inh_q;
    wire gsf_q;
    wire clr_ev = clk_en & acc_wr & health_hit & ~frame_bad;

    bcd_err_flag u_ser (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .set_ev  (clk_en & bad_acc),
        .clr_ev  (clr_ev),
        .flag_r  (ser_err_q)
    );

    bcd_err_flag u_ot (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .set_ev  (overtemp_ev),
        .clr_ev  (clr_ev),
        .flag_r  (ot_q)
    );

    bcd_err_flag u_inl (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .set_ev  (in_low_ev),
        .clr_ev  (clr_ev),
        .flag_r  (inl_q)
    );

    bcd_err_flag u_inh (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .set_ev  (in_high_ev),
        .clr_ev  (clr_ev),
        .flag_r  (inh_q)
    );

    bcd_err_flag u_gsf (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .set_ev  (gs_fault_ev),
        .clr_ev  (clr_ev),
        .flag_r  (gsf_q)
    );

    // Status byte: live ok bits on top, latched errors below
    wire [7:0] health_nxt;
    assign health_nxt[`BCD_F_OUT1_OK]  = out1_in_range;
    assign health_nxt[`BCD_F_OUT2_OK]  = out2_in_range;
    assign health_nxt[`BCD_F_GS_OK]    = gs_in_range;
    assign health_nxt[`BCD_F_OVERTEMP] = ot_q;
    assign health_nxt[`BCD_F_IN_LOW]   = inl_q;
    assign health_nxt[`BCD_F_IN_HIGH]  = inh_q;
    assign health_nxt[`BCD_F_SER_ERR]  = ser_err_q;
    assign health_nxt[`BCD_F_GS_FAULT] = gsf_q;

    // Read mux; bad access answers zero in the data field
    // Table hits first, then the separate case; the two never overlap
    reg [7:0] rdata_nxt;
    integer k;
    always @* begin
        rdata_nxt = 8'h00;
        for (k = 0; k < NREG; k = k + 1) begin
            if (hit[k]) begin
                rdata_nxt = store_q[k*8 +: 8];
            end
        end
        case (acc_addr)
            `BCD_A_HID_E:      rdata_nxt = hid_e_r;
            `BCD_A_SEL_CNT_LO: rdata_nxt = sel_edge_count[7:0];
            `BCD_A_SEL_CNT_HI: rdata_nxt = sel_edge_count[15:8];
            `BCD_A_IN_SUPPLY:  rdata_nxt = in_supply_meas;
            `BCD_A_DIE_TEMP:   rdata_nxt = die_temp_meas;
            `BCD_A_CALIB:      rdata_nxt = calib_result;
            `BCD_A_HEALTH:     rdata_nxt = health_status_r;
            default:           rdata_nxt = rdata_nxt;
        endcase
        if (bad_acc) begin
            rdata_nxt = 8'h00;
        end
    end

    // Registered answer and status image; an accepted write answers with its own write data
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_rdata_r     <= 8'h00;
            acc_ok_r        <= 1'b0;
            health_status_r <= 8'h00;
        end else if (clk_en) begin
            health_status_r <= health_nxt;
            // Idle cycles leave the last answer standing
            if (acc_wr | acc_rd) begin
                acc_rdata_r <= (acc_wr & ~bad_acc) ? acc_wdata : rdata_nxt;
                acc_ok_r    <= ~bad_acc;
            end
        end
    end

    // Field outputs registered from storage
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            // Routing and dividers
            gate_output_route_r         <= 4'h0;
            output1_divider_value_r     <= `BCD_R_DIV;
            output2_divider_value_r     <= `BCD_R_DIV;

            // Phase enables and timing fields
            output1_phase_on_r          <= 4'hF;
            output2_phase_on_r          <= 4'hF;
            output1_phase_delay_r       <= 5'h07;
            output1_phase_off_r         <= 3'h1;
            output2_phase_delay_r       <= 5'h07;
            output2_phase_off_r         <= 3'h1;

            // Phase routing and loop gains
            gate_phase_route_r          <= 4'h0;
            phase_output_choice_r       <= `BCD_R_PHASE_ASSIGN;
            output1_proportional_gain_r <= 4'h0;
            output2_proportional_gain_r <= 4'h0;
            output1_integral_gain_r     <= 4'h0;
            output2_integral_gain_r     <= 4'h0;

            // Analogue settings
            slope_comp_r                <= `BCD_R_SLOPE;
            phase_sense_resistor_r      <= `BCD_R_SENSE_R;
            gate_supply_setting_r       <= `BCD_R_GATE_SUPPLY;
            input_high_limit_r          <= `BCD_R_IN_HIGH;
            input_low_limit_r           <= `BCD_R_IN_LOW;
        end else if (clk_en) begin
            // Routing, dividers, phase enables and timing
            gate_output_route_r         <= store_q[0*8 +: 4];
            output1_divider_value_r     <= store_q[1*8 +: 8];
            output2_divider_value_r     <= store_q[2*8 +: 8];
            output1_phase_on_r          <= store_q[3*8 +: 4];
            output2_phase_on_r          <= store_q[4*8 +: 4];
            output1_phase_delay_r       <= store_q[5*8+`BCD_F_PHDEL_LO +: 5];
            output1_phase_off_r         <= store_q[5*8+`BCD_F_PHOFF_LO +: 3];
            output2_phase_delay_r       <= store_q[6*8+`BCD_F_PHDEL_LO +: 5];
            output2_phase_off_r         <= store_q[6*8+`BCD_F_PHOFF_LO +: 3];

            // Phase routing and loop gains
            gate_phase_route_r          <= store_q[7*8 +: 4];
            phase_output_choice_r       <= store_q[8*8 +: 8];
            output1_proportional_gain_r <= store_q[9*8 +: 4];
            output2_proportional_gain_r <= store_q[9*8+4 +: 4];
            output1_integral_gain_r     <= store_q[10*8 +: 4];
            output2_integral_gain_r     <= store_q[10*8+4 +: 4];

            // Analogue settings
            slope_comp_r                <= store_q[11*8 +: 8];
            phase_sense_resistor_r      <= store_q[12*8 +: 8];
            gate_supply_setting_r       <= store_q[13*8 +: 8];
            input_high_limit_r          <= store_q[14*8 +: 8];
            input_low_limit_r           <= store_q[15*8 +: 8];
        end
    end
endmodule // bcd_regs
`default_nettype wire

// ===== verif/bcd_host_model.sv
`default_nettype none
// Host side of the link: one-cycle accesses from bench commands
module bcd_host_model (
    // Clock
    input  wire logic       sys_clk,
    // Commands from the bench
    input  wire logic       cmd_v,
    input  wire logic       cmd_w,
    input  wire logic [6:0] cmd_a,
    input  wire logic [7:0] cmd_d,
    input  wire logic       cmd_bad,
    // Access toward the bank
    output var  logic       acc_wr,
    output var  logic       acc_rd,
    output var  logic [6:0] acc_addr,
    output var  logic [7:0] acc_wdata,
    output var  logic       frame_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    wire hidden = cmd_a inside {7'h19, 7'h25, 7'h26, 7'h2F, 7'h30};
    // Idle cycles scramble address and data so stale values never look valid
    always @(posedge sys_clk) begin
        acc_wr    <= cmd_v && cmd_w && !hidden;
        acc_rd    <= cmd_v && !(cmd_w && !hidden);
        acc_addr  <= cmd_v ? cmd_a : 7'($urandom);
        acc_wdata <= cmd_v ? cmd_d : 8'($urandom);
        frame_bad <= cmd_v && cmd_bad;
    end
endmodule // bcd_host_model
`default_nettype wire

// ===== verif/bcd_regs_assertions.sv
`default_nettype none
// Port checks on the register bank, bound from the bench
module bcd_chk (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic       clk_en,
    // Access and answer
    input wire logic       acc_wr,
    input wire logic [6:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    input wire logic       frame_bad,
    input wire logic       acc_rd,
    input wire logic       cfg_mode,
    input wire logic [7:0] acc_rdata_r,
    input wire logic       acc_ok_r,
    // Status sources and watched outputs
    input wire logic       out1_in_range,
    input wire logic       overtemp_ev,
    input wire logic       in_low_ev,
    input wire logic       in_high_ev,
    input wire logic       gs_fault_ev,
    input wire logic [7:0] output1_divider_value_r,
    input wire logic [4:0] output1_phase_delay_r,
    input wire logic [2:0] output1_phase_off_r,
    input wire logic [3:0] output1_proportional_gain_r,
    input wire logic [3:0] output2_proportional_gain_r,
    input wire logic [7:0] health_status_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Accepted config write; quiet events so a clear cannot lose to a set
    wire cw = clk_en && acc_wr && cfg_mode && !frame_bad;
    wire quiet = !(overtemp_ev || in_low_ev || in_high_ev || gs_fault_ev);

    a_locked_cfg_write: assert property (
        clk_en && acc_wr && !cfg_mode && acc_addr == 7'h09 |=> !acc_ok_r && acc_rdata_r == 8'h00)
        else $error("locked write taken");
    a_divider_store: assert property (
        cw && acc_addr == 7'h09 ##1 clk_en |=> output1_divider_value_r == $past(acc_wdata, 2))
        else $error("divider output wrong");
    a_phase_fields: assert property (
        cw && acc_addr == 7'h0D ##1 clk_en |=> {output1_phase_delay_r, output1_phase_off_r} == $past(acc_wdata, 2))
        else $error("phase fields wrong");
    a_gain_nibbles: assert property (
        cw && acc_addr == 7'h11 ##1 clk_en |=> {output2_proportional_gain_r, output1_proportional_gain_r} ==
        $past(acc_wdata, 2))
        else $error("gain nibbles wrong");
    a_diag_read_only: assert property (
        clk_en && acc_wr && acc_addr == 7'h45 |=> !acc_ok_r)
        else $error("diagnostic write taken");
    a_status_clear: assert property (
        clk_en && acc_wr && !frame_bad && acc_addr == 7'h5F && quiet ##1 clk_en |=> health_status_r[4:0] == 5'h00)
        else $error("status flags not cleared");
    a_bad_frame: assert property (
        clk_en && (acc_wr || acc_rd) && frame_bad |=> !acc_ok_r && acc_rdata_r == 8'h00)
        else $error("bad frame accepted");
    a_live_status: assert property (
        $past(rst_b) && $past(clk_en) |-> health_status_r[7] == $past(out1_in_range))
        else $error("live status bit wrong");
endmodule // bcd_chk
`default_nettype wire

// ===== verif/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] ADR [21] = '{7'h02, 7'h09, 7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h11, 7'h12,
        7'h13, 7'h14, 7'h15, 7'h1A, 7'h1B, 7'h19, 7'h25, 7'h26, 7'h2F, 7'h30};
    localparam logic [7:0] RST [21] = '{8'h00, 8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h39, 8'h39, 8'h00, 8'hE4, 8'h00, 8'h00,
        8'h88, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h82, 8'h27, 8'h3B, 8'hE8, 8'h09};
    localparam logic [6:0] DG [6] = '{7'h41, 7'h42, 7'h45, 7'h46, 7'h4C, 7'h5F};
    // Bank inputs and host commands
    logic        sys_clk, rst_b, clk_en, cfg_mode, cmd_v, cmd_w, cmd_bad;
    logic        out1_in_range, out2_in_range, gs_in_range, overtemp_ev, in_low_ev, in_high_ev, gs_fault_ev;
    logic [15:0] sel_edge_count;
    logic [7:0]  in_supply_meas, die_temp_meas, calib_result, cmd_d;
    logic [6:0]  cmd_a;
    // Access lines and bank outputs
    wire         acc_wr, acc_rd, frame_bad, acc_ok_r;
    wire  [6:0]  acc_addr;
    wire  [7:0]  acc_wdata, acc_rdata_r, health_status_r, output1_divider_value_r, output2_divider_value_r;
    wire  [7:0]  phase_output_choice_r, slope_comp_r, phase_sense_resistor_r, gate_supply_setting_r;
    wire  [7:0]  input_high_limit_r, input_low_limit_r;
    wire  [3:0]  gate_output_route_r, output1_phase_on_r, output2_phase_on_r, gate_phase_route_r;
    wire  [3:0]  output1_proportional_gain_r, output2_proportional_gain_r, output1_integral_gain_r;
    wire  [3:0]  output2_integral_gain_r;
    wire  [4:0]  output1_phase_delay_r, output2_phase_delay_r;
    wire  [2:0]  output1_phase_off_r, output2_phase_off_r;
    // Config outputs in table order, one comparison per access
    wire [111:0] cfg_obs = {gate_output_route_r, output1_divider_value_r, output2_divider_value_r, output1_phase_on_r,
        output2_phase_on_r, output1_phase_delay_r, output1_phase_off_r, output2_phase_delay_r, output2_phase_off_r,
        gate_phase_route_r, phase_output_choice_r, output2_proportional_gain_r, output1_proportional_gain_r,
        output2_integral_gain_r, output1_integral_gain_r, slope_comp_r, phase_sense_resistor_r,
        gate_supply_setting_r, input_high_limit_r, input_low_limit_r};
    // Reference state
    logic [7:0]  rv [21];
    logic [7:0]  last_d;
    logic [4:0]  flg;
    logic        last_o;
    int          mismatches, compares;

    bcd_host_model host (.*);
    bcd_regs DUT (.*);

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Hang guard
    initial begin
        repeat (50000) @(posedge sys_clk);
        mismatches++;
        end_sim();
    end

    task automatic check(input string what, input logic [111:0] seen, input logic [111:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (mismatches == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    function automatic int find(input logic [6:0] a);
        find = -1;
        for (int i = 0; i < 21; i++)
            if (ADR[i] == a)
                find = i;
    endfunction

    function automatic logic [111:0] cfg_img();
        cfg_img = {rv[0][3:0], rv[1], rv[2], rv[3][3:0], rv[4][3:0], rv[5], rv[6], rv[7][3:0], rv[8], rv[9],
            rv[10], rv[11], rv[12], rv[13], rv[14], rv[15]};
    endfunction

    // One access: predict, send, check answer then config outputs
    task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d, input logic bad);
        int k;
        logic eo;
        logic [7:0] ed, m;
        @(posedge sys_clk);
        k = find(a);
        eo = 1'b1;
        ed = 8'h00;
        m = (a inside {7'h02, 7'h0B, 7'h0C, 7'h0F}) ? 8'h0F : 8'hFF; // Unused upper bits stay unchecked
        if (!clk_en) begin
            eo = last_o; // Frozen bank keeps its last answer
            ed = last_d;
        end else if (bad)
            eo = 1'b0;
        else if (k >= 0 && !(w && k < 16 && !cfg_mode)) begin
            if (w)
                rv[k] = d;
            ed = rv[k];
        end else if (k >= 0 || (w && a != 7'h5F))
            eo = 1'b0;
        else
            case (a)
                7'h41: ed = sel_edge_count[7:0];
                7'h42: ed = sel_edge_count[15:8];
                7'h45: ed = in_supply_meas;
                7'h46: ed = die_temp_meas;
                7'h4C: ed = calib_result;
                7'h5F: ed = {out1_in_range, out2_in_range, gs_in_range, flg};
                default: eo = 1'b0;
            endcase
        if (clk_en && !eo) begin
            ed = 8'h00;
            flg[1] = 1'b1;
        end else if (clk_en && w && a == 7'h5F) begin
            m = 8'h00;
            flg = 5'h00;
        end
        last_o = eo;
        last_d = ed;
        {cmd_v, cmd_w, cmd_a, cmd_d, cmd_bad} <= {1'b1, w, a, d, bad};
        @(posedge sys_clk);
        cmd_v <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("answer ok", acc_ok_r, eo);
        check("answer data", acc_rdata_r & m, ed & m);
        @(posedge sys_clk);
        #1;
        check("config outputs", cfg_obs, cfg_img());
    endtask

    // Reset scan, locked and open writes, diagnostics, status, freeze, random traffic
    initial begin
        int r;
        logic [6:0] a;
        {rst_b, clk_en, cfg_mode, cmd_v, cmd_w, cmd_bad, cmd_a, cmd_d} = 21'h80000;
        {out1_in_range, out2_in_range, gs_in_range, overtemp_ev, in_low_ev, in_high_ev, gs_fault_ev} = 7'h00;
        {sel_edge_count, in_supply_meas, die_temp_meas, calib_result} = 40'h0;
        mismatches = 0;
        compares = 0;
        flg = 5'h00;
        last_o = 1'b0;
        last_d = 8'h00;
        for (int i = 0; i < 21; i++)
            rv[i] = RST[i];
        void'($urandom(91));
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 21; i++)
            access(1'b0, ADR[i], 8'h00, 1'b0);
        for (int i = 0; i < 16; i++)
            access(1'b1, ADR[i], 8'hA5, 1'b0);
        for (int i = 0; i < 5; i++)
            access(1'b1, DG[i], 8'hFF, 1'b0);
        @(posedge sys_clk);
        cfg_mode <= 1'b1;
        access(1'b1, 7'h09, 8'h00, 1'b1);
        for (int i = 0; i < 16; i++)
            access(1'b1, ADR[i], 8'h5A + 8'(i * 37), 1'b0);
        @(posedge sys_clk);
        {overtemp_ev, in_low_ev, in_high_ev, gs_fault_ev} <= 4'hF;
        @(posedge sys_clk);
        {overtemp_ev, in_low_ev, in_high_ev, gs_fault_ev} <= 4'h0;
        flg = flg | 5'h1D;
        access(1'b0, 7'h5F, 8'h00, 1'b0);
        access(1'b1, 7'h5F, 8'h00, 1'b0);
        access(1'b0, 7'h5F, 8'h00, 1'b0);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        access(1'b1, 7'h09, 8'h3C, 1'b0);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        access(1'b0, 7'h09, 8'h00, 1'b0);
        // Random traffic; hidden settings are steered away from all accesses, reads and writes
        for (int n = 0; n < 400; n++) begin
            @(posedge sys_clk);
            {out1_in_range, out2_in_range, gs_in_range, cfg_mode} <= 4'($urandom);
            {sel_edge_count, in_supply_meas} <= 24'($urandom);
            {die_temp_meas, calib_result} <= 16'($urandom);
            r = $urandom % 8;
            a = (r < 5) ? ADR[$urandom % 16] : (r == 5) ? DG[$urandom % 6] : 7'($urandom);
            if (find(a) > 15)
                a = a ^ 7'h40;
            access(1'($urandom), a, 8'($urandom), $urandom % 8 == 0);
        end
        end_sim();
    end
endmodule // testbench

bind bcd_regs bcd_chk u_chk (.*);
`default_nettype wire
